// [hdl/dts_draw_target_select.sv]
// draw-target selection: validates selection commands, holds targets
// per surface set and output colour, answers queries, gates writes
// assumes commands, queries and set info come from logic on clk_sys;
// context straps are pins and are synchronised before use
//
// Functional notes
// - default set single code enables none, one, two or four surfaces
// - no side named means both sides; no depth named means both
// - aux code is base plus i, enables aux i, i below aux count
// - user set selection names one attachment or nothing
// - default set single code naming unallocated surface is invalid-op
// - user set rejects default-set codes and attachment index too large
// - single selection clears every output colour above zero
// - list entry k goes to colour k, colours from n on cleared
// - hidden pair in list only alone, writes one left surface
// - list length negative or above maximum is invalid-value
// - repeated non-empty entry in list is invalid-op
// - multi-surface constant in list is invalid-enum for any set
// - hidden pair in list with length not one is invalid-op
// - list entry naming unallocated default surface is invalid-op
// - user set list entry i must be attachment i or empty
// - set id zero is default set; unknown id is invalid-op
// - writes go to selected surfaces, not empty or imageless points
// - allocated default surfaces follow strapped mono/stereo, buffering
// - reset targets: colour zero hidden, displayed or none; user att0
// - query returns stored target of colour i; unindexed means zero
// - maximum output target count is readable as a constant
`timescale 1ns/1ps
`default_nettype none
module dts_draw_target_select (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              ctx_stereo_pin,
   input  wire logic              ctx_double_pin,
   input  wire logic              ctx_default_pin,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire logic              cmd_list,
   input  wire logic              cmd_named,
   input  wire logic [1:0]        cmd_set_id,
   input  wire logic signed [4:0] cmd_len,
   input  wire logic [3:0][7:0]   cmd_code,
   output logic                   cmd_done,
   output logic [1:0]             cmd_error,
   output logic [1:0]             err_latched,
   input  wire logic              err_read,
   input  wire logic [1:0]        draw_set,
   input  wire logic [3:1]        set_exists,
   input  wire logic [7:0]        att_present,
   input  wire logic              query_valid,
   input  wire logic              query_indexed,
   input  wire logic [1:0]        query_idx,
   output logic                   query_ack,
   output logic [7:0]             query_data,
   output logic [2:0]             max_targets,
   output logic [3:0][7:0]        col_wr_mask,
   output logic                   col_user
);
   logic                   rst_q1;
   logic                   rst_n;
   logic [2:0]             pin_q1;
   logic [2:0]             pin_q2;
   logic                   cfg_st;
   logic                   cfg_db;
   logic                   cfg_df;
   dts_pkg::dts_state_t    state;
   logic                   accept;
   logic [1:0]             tgt;
   logic                   tgt_user;
   logic                   set_bad;
   logic                   len_bad;
   logic [3:0]             active;
   logic [3:0][7:0]        dec_mask;
   logic [3:0]             dec_enum;
   logic [3:0]             dec_op;
   logic [3:0]             dec_back;
   logic                   dup;
   logic                   back_bad;
   logic [1:0]             err;
   logic [3:0][3:0][7:0]   tab_code;
   logic [3:0][3:0][7:0]   tab_mask;
   logic [3:0]             init_bits;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_q1 <= 3'h0;
         pin_q2 <= 3'h0;
      end else begin
         pin_q1 <= {ctx_stereo_pin, ctx_double_pin, ctx_default_pin};
         pin_q2 <= pin_q1;
      end
   end

   // straps settle through the synchroniser before capture
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= dts_pkg::ST_SYNC0;
      end else begin
         case (state)
            dts_pkg::ST_SYNC0: state <= dts_pkg::ST_SYNC1;
            dts_pkg::ST_SYNC1: state <= dts_pkg::ST_CAPT;
            dts_pkg::ST_CAPT:  state <= dts_pkg::ST_RUN;
            default:           state <= dts_pkg::ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_st <= 1'b0;
         cfg_db <= 1'b0;
         cfg_df <= 1'b0;
      end else if (state == dts_pkg::ST_CAPT) begin
         {cfg_st, cfg_db, cfg_df} <= pin_q2;
      end
   end

   assign cmd_ready = state == dts_pkg::ST_RUN;
   assign accept = cmd_valid && cmd_ready;
   assign tgt = cmd_named ? cmd_set_id : draw_set;
   assign tgt_user = tgt != 2'h0;
   assign set_bad = cmd_named && tgt_user && !set_exists[tgt];
   assign len_bad = cmd_list
                    && (cmd_len[4] || cmd_len > dts_pkg::LEN_MAX);
   assign max_targets = dts_pkg::MAX_OUT_VAL;

   always_comb begin
      active = 4'h0;
      if (!cmd_list) begin
         active = 4'h1;
      end else if (!len_bad) begin
         for (int k = 0; k < dts_pkg::MAX_OUT; k++)
            active[k] = cmd_len > $signed(5'(k));
      end
   end

   for (genvar g = 0; g < dts_pkg::MAX_OUT; g++) begin : g_dec
      dts_decode u_dec (
         .code     (cmd_code[g]),
         .user     (tgt_user),
         .list     (cmd_list),
         .slot     (2'(g)),
         .stereo   (cfg_st),
         .dbl      (cfg_db),
         .has_def  (cfg_df),
         .mask     (dec_mask[g]),
         .bad_enum (dec_enum[g]),
         .bad_op   (dec_op[g]),
         .is_back  (dec_back[g])
      );
   end

   always_comb begin
      dup = 1'b0;
      for (int i = 0; i < dts_pkg::MAX_OUT; i++) begin
         for (int j = i + 1; j < dts_pkg::MAX_OUT; j++) begin
            if (active[i] && active[j]
                && cmd_code[i] != dts_pkg::CODE_NONE
                && cmd_code[i] == cmd_code[j])
               dup = 1'b1;
         end
      end
   end

   assign back_bad = cmd_list && !tgt_user && |(active & dec_back)
                     && cmd_len != dts_pkg::LEN_ONE;

   // named-set fault outranks length, then enum, then operation faults
   always_comb begin
      if (set_bad)
         err = dts_pkg::ERR_OP;
      else if (len_bad)
         err = dts_pkg::ERR_VALUE;
      else if (|(active & dec_enum))
         err = dts_pkg::ERR_ENUM;
      else if (|(active & dec_op) || back_bad || dup)
         err = dts_pkg::ERR_OP;
      else
         err = dts_pkg::ERR_NONE;
   end

   assign init_bits = !pin_q2[0] ? 4'h0
                    : pin_q2[1] ? {pin_q2[2], 3'h4}
                    : {2'h0, pin_q2[2], 1'b1};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tab_code <= '0;
         tab_mask <= '0;
      end else if (state == dts_pkg::ST_CAPT) begin
         tab_code <= '0;
         tab_mask <= '0;
         tab_code[0][0] <= !pin_q2[0] ? dts_pkg::CODE_NONE
                         : pin_q2[1] ? dts_pkg::CODE_BACK
                         : dts_pkg::CODE_FRONT;
         tab_mask[0][0] <= {4'h0, init_bits};
         for (int s = 1; s < 4; s++) begin
            tab_code[s][0] <= dts_pkg::CODE_ATT0;
            tab_mask[s][0] <= dts_pkg::MASK_ATT0;
         end
      end else if (accept && err == dts_pkg::ERR_NONE) begin
         for (int k = 0; k < dts_pkg::MAX_OUT; k++) begin
            tab_code[tgt][k] <= active[k] ? cmd_code[k]
                                          : dts_pkg::CODE_NONE;
            tab_mask[tgt][k] <= active[k] ? dec_mask[k]
                                          : dts_pkg::MASK_NONE;
         end
      end
   end

   // imageless attachments drop out of the enable here, not at select
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         col_wr_mask <= '0;
         col_user <= 1'b0;
      end else begin
         for (int k = 0; k < dts_pkg::MAX_OUT; k++)
            col_wr_mask[k] <= tab_mask[draw_set][k]
               & ((draw_set != 2'h0) ? att_present
                                     : dts_pkg::MASK_ALL);
         col_user <= draw_set != 2'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         query_ack <= 1'b0;
         query_data <= dts_pkg::CODE_NONE;
      end else begin
         query_ack <= query_valid && cmd_ready;
         if (query_valid && cmd_ready)
            query_data <= tab_code[draw_set]
               [query_indexed ? query_idx : 2'h0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_done <= 1'b0;
         cmd_error <= dts_pkg::ERR_NONE;
      end else begin
         cmd_done <= accept;
         if (accept)
            cmd_error <= err;
      end
   end

   // first error is kept; a new error in the read cycle still lands
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         err_latched <= dts_pkg::ERR_NONE;
      else if (accept && err != dts_pkg::ERR_NONE
               && (err_latched == dts_pkg::ERR_NONE || err_read))
         err_latched <= err;
      else if (err_read)
         err_latched <= dts_pkg::ERR_NONE;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   property p_reject_keeps;
      accept && err != dts_pkg::ERR_NONE |=> $stable(tab_code)
         && $stable(tab_mask) && cmd_error == $past(err);
   endproperty
   a_reject_keeps: assert property (p_reject_keeps)
      else $error("rejected command changed target state");

   property p_single_clears;
      accept && !cmd_list && err == dts_pkg::ERR_NONE
         |=> tab_code[$past(tgt)][3:1] == '0;
   endproperty
   a_single_clears: assert property (p_single_clears)
      else $error("single select left upper colours set");

   property p_list_one;
      accept && cmd_list && cmd_len == dts_pkg::LEN_ONE
         && err == dts_pkg::ERR_NONE
         |=> tab_code[$past(tgt)][0] == $past(cmd_code[0])
         && tab_code[$past(tgt)][3:1] == '0;
   endproperty
   a_list_one: assert property (p_list_one)
      else $error("list of one stored wrongly");

   property p_len_bad;
      accept && cmd_list && !set_bad && cmd_len[4]
         |=> cmd_done && cmd_error == dts_pkg::ERR_VALUE;
   endproperty
   a_len_bad: assert property (p_len_bad)
      else $error("negative length not flagged invalid-value");

   property p_multi_enum;
      accept && cmd_list && !set_bad && !len_bad && active[0]
         && cmd_code[0] == dts_pkg::CODE_FAB
         |=> cmd_error == dts_pkg::ERR_ENUM;
   endproperty
   a_multi_enum: assert property (p_multi_enum)
      else $error("multi-surface list entry not invalid-enum");

   property p_named_bad;
      accept && cmd_named && cmd_set_id != 2'h0
         && !set_exists[cmd_set_id]
         |=> cmd_done && cmd_error == dts_pkg::ERR_OP;
   endproperty
   a_named_bad: assert property (p_named_bad)
      else $error("unknown set id not invalid-op");

   property p_gate_none;
      tab_mask[draw_set][0] == dts_pkg::MASK_NONE
         |=> col_wr_mask[0] == dts_pkg::MASK_NONE;
   endproperty
   a_gate_none: assert property (p_gate_none)
      else $error("empty selection still enables writes");

   // a read pulse may legally clear the latch, so both cycles exclude it
   property p_err_hold;
      err_latched != dts_pkg::ERR_NONE && !err_read ##1 !err_read
         |-> $stable(err_latched) ##1 $stable(err_latched);
   endproperty
   a_err_hold: assert property (p_err_hold)
      else $error("latched error lost before read");

   c_list_ok: cover property (accept && cmd_list
      && cmd_len == dts_pkg::LEN_MAX && err == dts_pkg::ERR_NONE);
   c_err_op: cover property (accept && err == dts_pkg::ERR_OP);
   c_query: cover property (query_valid && cmd_ready && query_indexed);
   c_user_gate: cover property (col_user && col_wr_mask[0] != '0);
endmodule
`default_nettype wire

// [shared/dts_pkg.sv]
// constants for the draw-target selection unit
// assumes one 10 MHz clock domain; codes are the host command encoding
package dts_pkg;
   // target codes carried in the command stream
   localparam logic [7:0] CODE_NONE  = 8'h00;
   localparam logic [7:0] CODE_FL    = 8'h01;
   localparam logic [7:0] CODE_FR    = 8'h02;
   localparam logic [7:0] CODE_BL    = 8'h03;
   localparam logic [7:0] CODE_BR    = 8'h04;
   localparam logic [7:0] CODE_FRONT = 8'h05;
   localparam logic [7:0] CODE_BACK  = 8'h06;
   localparam logic [7:0] CODE_LEFT  = 8'h07;
   localparam logic [7:0] CODE_RIGHT = 8'h08;
   localparam logic [7:0] CODE_FAB   = 8'h09;
   // auxiliary_surface_code i = CODE_AUX0 + i
   localparam logic [7:0] CODE_AUX0  = 8'h10;
   // attachment_point_code i = CODE_ATT0 + i
   localparam logic [7:0] CODE_ATT0  = 8'h20;
   localparam logic [3:0] AUX_NUM    = 4'h4;
   localparam logic [3:0] MAX_ATT    = 4'h8;
   localparam int         MAX_OUT    = 4;
   localparam logic [2:0] MAX_OUT_VAL = 3'h4;
   localparam logic signed [4:0] LEN_MAX = 5'sh4;
   localparam logic signed [4:0] LEN_ONE = 5'sh1;
   // surface enable masks: [0] disp-left [1] disp-right [2] hidden-left
   // [3] hidden-right [7:4] aux; user sets use [7:0] as attachments
   localparam logic [7:0] MASK_NONE  = 8'h00;
   localparam logic [7:0] MASK_FL    = 8'h01;
   localparam logic [7:0] MASK_BL    = 8'h04;
   localparam logic [7:0] MASK_AUX0  = 8'h10;
   localparam logic [7:0] MASK_ATT0  = 8'h01;
   localparam logic [7:0] MASK_ALL   = 8'hff;
   // error classes
   localparam logic [1:0] ERR_NONE   = 2'h0;
   localparam logic [1:0] ERR_ENUM   = 2'h1;
   localparam logic [1:0] ERR_VALUE  = 2'h2;
   localparam logic [1:0] ERR_OP     = 2'h3;
   typedef enum logic [1:0] {
      ST_SYNC0,
      ST_SYNC1,
      ST_CAPT,
      ST_RUN
   } dts_state_t;
endpackage

// [hdl/dts_decode.sv]
// decodes one target code into a surface mask and its error flags
// assumes context configuration is stable while a command is decoded
`timescale 1ns/1ps
`default_nettype none
module dts_decode (
   input  wire logic [7:0] code,
   input  wire logic       user,
   input  wire logic       list,
   input  wire logic [1:0] slot,
   input  wire logic       stereo,
   input  wire logic       dbl,
   input  wire logic       has_def,
   output logic      [7:0] mask,
   output logic            bad_enum,
   output logic            bad_op,
   output logic            is_back
);
   logic [3:0] ind;
   logic       multi;
   logic [3:0] alloc;
   logic [3:0] idx;
   logic       is_aux;
   logic       is_att;

   assign idx     = code[3:0];
   assign is_aux  = code[7:4] == dts_pkg::CODE_AUX0[7:4];
   assign is_att  = code[7:4] == dts_pkg::CODE_ATT0[7:4];
   assign is_back = code == dts_pkg::CODE_BACK;
   // mono has left only, single-buffered has displayed only
   assign alloc   = {4{has_def}} & {dbl & stereo, dbl, stereo, 1'b1};

   always_comb begin
      ind = 4'h0;
      multi = 1'b0;
      case (code)
         dts_pkg::CODE_FL:    ind = 4'h1;
         dts_pkg::CODE_FR:    ind = 4'h2;
         dts_pkg::CODE_BL:    ind = 4'h4;
         dts_pkg::CODE_BR:    ind = 4'h8;
         dts_pkg::CODE_BACK:  ind = 4'hc;
         dts_pkg::CODE_FRONT: begin
            ind = 4'h3;
            multi = 1'b1;
         end
         dts_pkg::CODE_LEFT: begin
            ind = 4'h5;
            multi = 1'b1;
         end
         dts_pkg::CODE_RIGHT: begin
            ind = 4'ha;
            multi = 1'b1;
         end
         dts_pkg::CODE_FAB: begin
            ind = 4'hf;
            multi = 1'b1;
         end
         default: ind = 4'h0;
      endcase
   end

   always_comb begin
      mask = dts_pkg::MASK_NONE;
      bad_enum = 1'b0;
      bad_op = 1'b0;
      if (list && multi) begin
         bad_enum = 1'b1;
      end else if (code == dts_pkg::CODE_NONE) begin
         mask = dts_pkg::MASK_NONE;
      end else if (!is_att && !is_aux && ind == 4'h0) begin
         bad_enum = 1'b1;
      end else if (user) begin
         if (!is_att || idx >= dts_pkg::MAX_ATT) begin
            bad_op = 1'b1;
         end else if (list && idx != {2'h0, slot}) begin
            bad_op = 1'b1;
         end else begin
            mask = dts_pkg::MASK_ATT0 << idx;
         end
      end else begin
         if (is_aux) begin
            if (idx < dts_pkg::AUX_NUM)
               mask = (dts_pkg::MASK_AUX0 << idx) & {8{has_def}};
         end else if (list && is_back) begin
            // one-entry hidden pair writes one left surface only
            mask = (dbl ? dts_pkg::MASK_BL : dts_pkg::MASK_FL)
                   & {4'h0, alloc};
         end else begin
            mask = {4'h0, ind & alloc};
         end
         bad_op = mask == dts_pkg::MASK_NONE;
      end
   end
endmodule
`default_nettype wire

// [testbench/dts_host_model.sv]
// host-side model: bound drawing set and attachment images
// assumes the bench requests binds; values move on clk_sys
`timescale 1ns/1ps
`default_nettype none
module dts_host_model (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [1:0] bind_req,
   input  wire logic [7:0] att_req,
   output logic      [1:0] draw_set,
   output logic      [3:1] set_exists,
   output logic      [7:0] att_present
);
   // sets 1 and 2 exist; 3 never does, so named id 3 stays illegal
   assign set_exists = 3'h3;
   // one image per point, so no image is ever multiply attached
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         draw_set    <= 2'h0;
         att_present <= 8'h00;
      end else begin
         draw_set    <= bind_req;
         att_present <= att_req;
      end
   end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench: integer model of target tables and errors
// assumes dts_host_model supplies the bound set and images
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                clk_sys, rst_b, st, db, df, cv, cl, cn, er, qv, qi;
   logic [1:0]          sid, qx, bq;
   logic signed [4:0]   len;
   logic [3:0][7:0]     cc;
   logic [7:0]          aq;
   wire logic           cr, cd, qa, cu;
   wire logic [1:0]     ce, el, ds;
   wire logic [2:0]     mt;
   wire logic [3:1]     se;
   wire logic [7:0]     ap, qd;
   wire logic [3:0][7:0] wm;
   int n_fail, total_checks, lat, dset, att, m;
   int mc[4][4], mm[4][4], c[4];
   int tbl[20] = '{0,1,2,3,4,5,6,7,8,9,16,19,20,32,33,34,35,39,40,48};

   dts_draw_target_select u_dts_draw_target_select (
      .clk_sys(clk_sys), .rst_b(rst_b), .ctx_stereo_pin(st),
      .ctx_double_pin(db), .ctx_default_pin(df), .cmd_valid(cv),
      .cmd_ready(cr), .cmd_list(cl), .cmd_named(cn), .cmd_set_id(sid),
      .cmd_len(len), .cmd_code(cc), .cmd_done(cd), .cmd_error(ce),
      .err_latched(el), .err_read(er), .draw_set(ds), .set_exists(se),
      .att_present(ap), .query_valid(qv), .query_indexed(qi),
      .query_idx(qx), .query_ack(qa), .query_data(qd), .max_targets(mt),
      .col_wr_mask(wm), .col_user(cu));
   dts_host_model u_dts_host_model (
      .clk_sys(clk_sys), .rst_b(rst_b), .bind_req(bq), .att_req(aq),
      .draw_set(ds), .set_exists(se), .att_present(ap));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   function automatic int alloc();
      if (!df) return 0;
      return 241 | (st ? 2 : 0) | (db ? 4 : 0) | (st && db ? 8 : 0);
   endfunction

   function automatic int cmask(int x);
      int t[10] = '{0,1,2,4,8,3,12,5,10,15};
      if (x >= 16) return 1 << (x - 12);
      return t[x];
   endfunction

   // error class of one entry; mask it would enable goes to m
   function automatic int ent(int x, int u, int l, int k, int n);
      m = 0;
      if (x == 0) return 0;
      if (x > 9 && x < 16 || x >= 48) return 1;
      if (l && (x == 5 || x > 6 && x < 10)) return 1;
      if (u) begin
         if (x < 32 || x >= 40 || l && x != 32 + k) return 3;
         m = 1 << (x - 32);
         return 0;
      end
      if (x >= 20) return 3;
      if (l && x == 6) begin
         m = (db ? 4 : 1) & alloc();
         return (n == 1 && m != 0) ? 0 : 3;
      end
      m = cmask(x) & alloc();
      return m == 0 ? 3 : 0;
   endfunction

   task automatic query(bit ix, int i);
      @(posedge clk_sys);
      qv <= 1'b1;
      qi <= ix;
      qx <= i[1:0];
      @(posedge clk_sys);
      qv <= 1'b0;
      #1;
      check("query_ack", qa, 8'h01);
      check("query_data", qd, 8'(mc[dset][ix ? i : 0]));
   endtask

   task automatic settle();
      @(posedge clk_sys);
      #1;
      for (int k = 0; k < 4; k++)
         check("col_wr_mask", wm[k],
               8'(mm[dset][k] & (dset != 0 ? att : 255)));
      check("col_user", {7'h0, cu}, 8'(dset != 0));
      for (int k = 0; k < 4; k++) query(1, k);
      query(0, 3);
   endtask

   task automatic cmd(bit l, bit nm, int s, int n, int x[4]);
      int e, en, op, r, nn, tg;
      int mk[4];
      tg = nm ? s : dset;
      nn = l ? n : 1;
      en = 0;
      op = 0;
      e = 0;
      if (nm && s != 0 && se[s] !== 1'b1) e = 3;
      else if (l && (n < 0 || n > 4)) e = 2;
      else begin
         for (int k = 0; k < nn; k++) begin
            r = ent(x[k], tg != 0, l, k, n);
            mk[k] = m;
            if (r == 1) en = 1;
            if (r == 3) op = 1;
            for (int j = 0; j < k; j++)
               if (x[j] != 0 && x[j] == x[k]) op = 1;
         end
         e = en ? 1 : op ? 3 : 0;
      end
      @(posedge clk_sys);
      cv <= 1'b1;
      cl <= l;
      cn <= nm;
      sid <= s[1:0];
      len <= n[4:0];
      cc <= {x[3][7:0], x[2][7:0], x[1][7:0], x[0][7:0]};
      @(posedge clk_sys);
      cv <= 1'b0;
      #1;
      check("cmd_done", cd, 8'h01);
      // class per rule
      check("cmd_error", {6'h0, ce}, 8'(e));
      if (lat == 0) lat = e;
      check("err_latched", {6'h0, el}, 8'(lat));
      if (e == 0) for (int k = 0; k < 4; k++) begin
         mc[tg][k] = k < nn ? x[k] : 0;
         mm[tg][k] = k < nn ? mk[k] : 0;
      end
      settle();
   endtask

   task automatic bind_set(int s, int a);
      @(posedge clk_sys);
      bq <= s[1:0];
      aq <= a[7:0];
      dset = s;
      att = a;
      @(posedge clk_sys);
      settle();
   endtask

   task automatic clr();
      @(posedge clk_sys);
      er <= 1'b1;
      @(posedge clk_sys);
      er <= 1'b0;
      #1;
      lat = 0;
      check("err_latched", {6'h0, el}, 8'h00);
   endtask

   task automatic boot(bit s, bit d, bit f);
      int w;
      @(posedge clk_sys);
      rst_b <= 1'b0;
      st <= s;
      db <= d;
      df <= f;
      bq <= 2'h0;
      aq <= 8'h00;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      dset = 0;
      att = 0;
      lat = 0;
      for (int t = 0; t < 4; t++) for (int k = 0; k < 4; k++) begin
         mc[t][k] = (t != 0 && k == 0) ? 32 : 0;
         mm[t][k] = (t != 0 && k == 0) ? 1 : 0;
      end
      mc[0][0] = f ? (d ? 6 : 5) : 0;
      mm[0][0] = f ? cmask(mc[0][0]) & alloc() : 0;
      w = 0;
      while (cr !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         w++;
         if (w > 20) begin
            n_fail++;
            print_verdict();
         end
      end
      // two reset flops, two sync states, then capture
      check("cmd_ready_delay", 8'(w), 8'h05);
      settle();
   endtask

   task automatic run();
      cmd(1, 0, 0, 1, '{6, 0, 0, 0});
      cmd(1, 0, 0, 2, '{6, 1, 0, 0});
      cmd(0, 0, 0, 0, '{19, 0, 0, 0});
      cmd(0, 0, 0, 0, '{20, 0, 0, 0});
      clr();
      cmd(1, 0, 0, 5, '{1, 0, 0, 0});
      cmd(1, 0, 0, -1, '{1, 0, 0, 0});
      cmd(1, 0, 0, 3, '{1, 0, 1, 0});
      for (int i = 5; i < 10; i++) cmd(1, 0, 0, 1, '{i, 0, 0, 0});
      cmd(0, 0, 0, 0, '{2, 0, 0, 0});
      cmd(0, 1, 3, 0, '{0, 0, 0, 0});
      clr();
      cmd(0, 1, 1, 0, '{33, 0, 0, 0});
      bind_set(1, 15);
      cmd(1, 0, 0, 4, '{32, 0, 34, 35});
      cmd(1, 0, 0, 2, '{33, 32, 0, 0});
      cmd(0, 0, 0, 0, '{40, 0, 0, 0});
      cmd(0, 0, 0, 0, '{1, 0, 0, 0});
      bind_set(1, 5);
      bind_set(0, 0);
      for (int i = 0; i < 40; i++) begin
         for (int k = 0; k < 4; k++) c[k] = tbl[$urandom_range(19)];
         if (i % 8 == 0) bind_set($urandom_range(2), $urandom_range(255));
         cmd($urandom_range(1), $urandom_range(1), $urandom_range(3),
             int'($urandom_range(6)) - 1, c);
         if (i % 5 == 4) clr();
      end
   endtask

   initial begin
      rst_b = 1'b0;
      {st, db, df, cv, cl, cn, er, qv, qi} = 9'h000;
      {sid, qx, bq} = 6'h00;
      len = 5'sh0;
      cc = 32'h0000_0000;
      aq = 8'h00;
      n_fail = 0;
      total_checks = 0;
      m = $urandom(32'h0000_336a);
      boot(0, 0, 0);
      check("max_targets", {5'h0, mt}, 8'h04);
      boot(0, 0, 1);
      run();
      boot(1, 1, 1);
      run();
      print_verdict();
   end
endmodule
`default_nettype wire
